// ---- verilog/led_sink_defines.svh ----
`ifndef LED_SINK_DEFINES_SVH
`define LED_SINK_DEFINES_SVH

// Shift chain and counter geometry
`define CHAIN_WIDTH 16
`define CNT_WIDTH 4
`define CNT_MAX 4'hF
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

// Edge counts that select a command
`define CMD_GHOST_MIN 4'h1
`define CMD_GHOST_MAX 4'h3
`define CMD_CONFIG_COUNT 4'hB

// Pre-charge level field of the configuration register
`define PRE_LSB 11
`define PRE_MSB 14
`define PRE_RESET 4'h0

// Reset values
`define WORD_RESET 16'h0000
`define CONFIG_RESET 16'h0000

`endif

// ---- verilog/led_sink_pkg.sv ----
`default_nettype none
package led_sink_pkg;
  typedef enum logic [1:0] {
    PARSE_IDLE = 2'b00,
    PARSE_HIGH = 2'b01,
    PARSE_APPLY = 2'b10
  } parse_state_t;

  typedef enum logic [1:0] {
    CMD_LATCH_PLAIN = 2'b00,
    CMD_LATCH_GHOST = 2'b01,
    CMD_CONFIG_WRITE = 2'b10,
    CMD_RESERVED = 2'b11
  } cmd_t;
endpackage
`default_nettype wire

// ---- verilog/link_if.sv ----
`default_nettype none
`include "led_sink_defines.svh"
interface link_if;
  logic [`CHAIN_WIDTH-1:0] word;
  logic [`CNT_WIDTH-1:0] edge_count;
  logic pulse_tag;
  modport link (output word, output edge_count, output pulse_tag);
  modport core (input word, input edge_count, input pulse_tag);
endinterface
`default_nettype wire

// ---- verilog/sync3.sv ----
`default_nettype none
module sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk, // Destination clock
  input wire logic nrst, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Foreign-domain level
  output logic [WIDTH-1:0] q // Filtered level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1 <= RESET_VALUE[i];
          s2 <= RESET_VALUE[i];
          s3 <= RESET_VALUE[i];
        end else begin
          s1 <= d[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // Accept a change once stages two and three agree
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          q[i] <= RESET_VALUE[i];
        end else if (s2 == s3) begin
          q[i] <= s3;
        end
      end
    end
  endgenerate
endmodule // sync3
`default_nettype wire

// ---- verilog/link_shifter.sv ----
`default_nettype none
`include "led_sink_defines.svh"
module link_shifter
  import led_sink_pkg::*;
(
  input wire logic shift_clock, // Link clock from controller
  input wire logic nrst, // Async reset, active low
  input wire logic serial_data_in, // Serial data or command bit
  input wire logic command_strobe, // Command strobe, high active
  output logic serial_chain_out, // Bit to next driver
  link_if.link lk // Word, count and tag to core
);
  logic [`CHAIN_WIDTH-1:0] shift_reg;
  logic [`CNT_WIDTH-1:0] count;
  logic strobe_q;
  logic tag;

  always_ff @(posedge shift_clock or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= `WORD_RESET;
    end else begin
      shift_reg <= {shift_reg[`CHAIN_WIDTH-2:0], serial_data_in};
    end
  end

  // last stage drives chain
  // No extra flop here, or a cascade would see 17 stages per driver
  assign serial_chain_out = shift_reg[`CHAIN_WIDTH-1];

  always_ff @(posedge shift_clock or negedge nrst) begin
    if (!nrst) begin
      strobe_q <= 1'b0;
      count <= `CNT_ZERO;
      tag <= 1'b0;
    end else begin
      strobe_q <= command_strobe;
      if (command_strobe && !strobe_q) begin
        count <= `CNT_ONE;
        tag <= ~tag;
      end else if (command_strobe && count != `CNT_MAX) begin
        count <= count + `CNT_ONE;
      end
    end
  end

  assign lk.word = shift_reg;
  assign lk.edge_count = count;
  assign lk.pulse_tag = tag;

  property p_shift;
    @(posedge shift_clock) disable iff (!nrst)
    1'b1 |=> shift_reg == {$past(shift_reg[`CHAIN_WIDTH-2:0]), $past(serial_data_in)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not shift");

  property p_chain;
    @(posedge shift_clock) disable iff (!nrst)
    1'b1 |=> serial_chain_out == $past(shift_reg[`CHAIN_WIDTH-2]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain output wrong");

  property p_count;
    @(posedge shift_clock) disable iff (!nrst)
    command_strobe && strobe_q && count < `CNT_MAX |=> count == $past(count) + `CNT_ONE;
  endproperty
  a_count: assert property (p_count) else $error("edge count did not advance");
endmodule // link_shifter
`default_nettype wire

// ---- verilog/led_sink_serial_latch_ctrl.sv ----
`default_nettype none
`include "led_sink_defines.svh"
module led_sink_serial_latch_ctrl
  import led_sink_pkg::*;
(
  input wire logic core_clk, // Core clock, 25 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic shift_clock, // Link shift clock
  input wire logic serial_data_in, // Serial data in
  input wire logic command_strobe, // Command strobe pin
  input wire logic output_gate_low, // Output enable, active low
  output logic serial_chain_out, // Serial out to next driver
  output logic [`CHAIN_WIDTH-1:0] sink_channels, // Channel on flags
  output logic [`PRE_MSB-`PRE_LSB:0] precharge_level, // Pre-charge level field
  output logic precharge_active, // Pre-charge interval running
  output logic ghost_reduction_on, // Last latch used ghost reduction
  output logic latch_event // One-cycle latch pulse
);
  link_if lk();

  link_shifter u_link (
    .shift_clock(shift_clock),
    .nrst(nrst),
    .serial_data_in(serial_data_in),
    .command_strobe(command_strobe),
    .serial_chain_out(serial_chain_out),
    .lk(lk.link)
  );

  logic strobe_s;
  logic gate_s;
  logic tag_s;

  sync3 #(
    .WIDTH(3),
    .RESET_VALUE(3'b010)
  ) u_sync (
    .clk(core_clk),
    .nrst(nrst),
    .d({command_strobe, output_gate_low, lk.pulse_tag}),
    .q({strobe_s, gate_s, tag_s})
  );

  parse_state_t state;
  parse_state_t next_state;
  cmd_t cmd;
  logic [`CHAIN_WIDTH-1:0] held_word;
  logic [`CHAIN_WIDTH-1:0] display;
  logic [`CHAIN_WIDTH-1:0] ghost_precharge_config;
  logic strobe_prev;
  logic gate_prev;
  logic tag_ref;
  logic strobe_rise;
  logic strobe_fall;
  logic gate_fall;
  logic [`CNT_WIDTH-1:0] seen_count;
  logic next_latch;

  assign strobe_rise = strobe_s && !strobe_prev;
  assign strobe_fall = !strobe_s && strobe_prev;
  assign gate_fall = !gate_s && gate_prev;
  // A pulse with no clock edge leaves the link tag untouched
  assign seen_count = (tag_s == tag_ref) ? `CNT_ZERO : lk.edge_count;
  assign next_latch = (state == PARSE_APPLY) &&
                      (cmd == CMD_LATCH_PLAIN || cmd == CMD_LATCH_GHOST);

  function automatic cmd_t decode(input logic [`CNT_WIDTH-1:0] n);
    cmd_t c;
    c = CMD_RESERVED;
    if (n == `CNT_ZERO) begin
      c = CMD_LATCH_PLAIN;
    end else if (n >= `CMD_GHOST_MIN && n <= `CMD_GHOST_MAX) begin
      c = CMD_LATCH_GHOST;
    end else if (n == `CMD_CONFIG_COUNT) begin
      c = CMD_CONFIG_WRITE;
    end
    return c;
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_prev <= 1'b0;
      gate_prev <= 1'b1;
    end else begin
      strobe_prev <= strobe_s;
      gate_prev <= gate_s;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      PARSE_IDLE: begin
        if (strobe_rise) begin
          next_state = PARSE_HIGH;
        end
      end
      PARSE_HIGH: begin
        if (strobe_fall) begin
          next_state = PARSE_APPLY;
        end
      end
      PARSE_APPLY: begin
        next_state = PARSE_IDLE;
      end
      default: begin
        next_state = PARSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= PARSE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= CMD_RESERVED;
      held_word <= `WORD_RESET;
      tag_ref <= 1'b0;
    end else if (state == PARSE_HIGH && strobe_fall) begin
      cmd <= decode(seen_count);
      held_word <= lk.word;
      tag_ref <= tag_s;
    end
  end

  // parallel display latch; leaves others alone
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      display <= `WORD_RESET;
      ghost_reduction_on <= 1'b0;
    end else if (next_latch) begin
      display <= held_word;
      ghost_reduction_on <= (cmd == CMD_LATCH_GHOST);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latch_event <= 1'b0;
    end else begin
      latch_event <= next_latch;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ghost_precharge_config <= `CONFIG_RESET;
    end else if (state == PARSE_APPLY && cmd == CMD_CONFIG_WRITE) begin
      ghost_precharge_config <= held_word;
    end
  end

  assign precharge_level = ghost_precharge_config[`PRE_MSB:`PRE_LSB];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      precharge_active <= 1'b0;
    end else if (next_latch && cmd == CMD_LATCH_GHOST && gate_s) begin
      precharge_active <= 1'b1;
    end else if (gate_fall || !gate_s) begin
      precharge_active <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sink_channels <= `WORD_RESET;
    end else begin
      sink_channels <= gate_s ? `WORD_RESET : display;
    end
  end

  property p_gate_off;
    @(posedge core_clk) disable iff (!nrst)
    gate_s |=> sink_channels == `WORD_RESET;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("channels on while gate high");

  property p_gate_on;
    @(posedge core_clk) disable iff (!nrst)
    !gate_s |=> sink_channels == $past(display);
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("channels differ from display");

  property p_latch_plain;
    @(posedge core_clk) disable iff (!nrst)
    state == PARSE_HIGH && strobe_fall && seen_count == `CNT_ZERO
      |=> ##1 latch_event && !ghost_reduction_on && display == $past(lk.word, 2);
  endproperty
  a_latch_plain: assert property (p_latch_plain) else $error("plain latch failed");

  property p_latch_ghost;
    @(posedge core_clk) disable iff (!nrst)
    state == PARSE_HIGH && strobe_fall && seen_count >= `CMD_GHOST_MIN && seen_count <= `CMD_GHOST_MAX
      |=> ##1 latch_event && ghost_reduction_on;
  endproperty
  a_latch_ghost: assert property (p_latch_ghost) else $error("ghost latch failed");

  property p_config;
    @(posedge core_clk) disable iff (!nrst)
    state == PARSE_HIGH && strobe_fall && seen_count == `CMD_CONFIG_COUNT
      |=> ##1 ghost_precharge_config == $past(lk.word, 2) && !latch_event;
  endproperty
  a_config: assert property (p_config) else $error("configuration not written");

  property p_reserved;
    @(posedge core_clk) disable iff (!nrst)
    state == PARSE_APPLY && cmd == CMD_RESERVED
      |=> $stable(display) && $stable(ghost_precharge_config) && !latch_event;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved command changed state");

  property p_all_bits;
    @(posedge core_clk) disable iff (!nrst)
    next_latch |=> display == $past(held_word);
  endproperty
  a_all_bits: assert property (p_all_bits) else $error("latch lost bits");

  property p_level;
    @(posedge core_clk) disable iff (!nrst)
    state == PARSE_APPLY && cmd == CMD_CONFIG_WRITE
      |=> precharge_level == $past(held_word[`PRE_MSB:`PRE_LSB]);
  endproperty
  a_level: assert property (p_level) else $error("pre-charge level mismatch");

  property p_pre_start;
    @(posedge core_clk) disable iff (!nrst)
    next_latch && cmd == CMD_LATCH_GHOST && gate_s |=> precharge_active;
  endproperty
  a_pre_start: assert property (p_pre_start) else $error("pre-charge did not start");

  property p_pre_end;
    @(posedge core_clk) disable iff (!nrst)
    gate_fall |=> !precharge_active;
  endproperty
  a_pre_end: assert property (p_pre_end) else $error("pre-charge outlived gate fall");

  property p_hold;
    @(posedge core_clk) disable iff (!nrst)
    !next_latch |=> $stable(display);
  endproperty
  a_hold: assert property (p_hold) else $error("display changed without latch");

  property p_apply_once;
    @(posedge core_clk) disable iff (!nrst)
    state == PARSE_APPLY |=> state == PARSE_IDLE;
  endproperty
  a_apply_once: assert property (p_apply_once) else $error("command applied twice");

  property p_latch_pulse;
    @(posedge core_clk) disable iff (!nrst)
    latch_event |=> !latch_event;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("latch pulse too long");

  property p_config_keep;
    @(posedge core_clk) disable iff (!nrst)
    !(state == PARSE_APPLY && cmd == CMD_CONFIG_WRITE) |=> $stable(ghost_precharge_config);
  endproperty
  a_config_keep: assert property (p_config_keep) else $error("configuration changed without write");

  property p_pre_hold;
    @(posedge core_clk) disable iff (!nrst)
    precharge_active && gate_s |=> precharge_active;
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("pre-charge ended while gate high");

  c_plain: cover property (@(posedge core_clk) disable iff (!nrst)
    latch_event && !ghost_reduction_on);
  c_ghost: cover property (@(posedge core_clk) disable iff (!nrst)
    latch_event && ghost_reduction_on ##[1:20] gate_fall);
  c_config: cover property (@(posedge core_clk) disable iff (!nrst)
    state == PARSE_APPLY && cmd == CMD_CONFIG_WRITE);
  c_reserved: cover property (@(posedge core_clk) disable iff (!nrst)
    state == PARSE_APPLY && cmd == CMD_RESERVED);
  c_pre_cut: cover property (@(posedge core_clk) disable iff (!nrst)
    precharge_active ##1 !precharge_active);
endmodule // led_sink_serial_latch_ctrl
`default_nettype wire

// ---- bench/led_ctl_model.sv ----
`default_nettype none
module led_ctl_model (
  output logic shift_clock, // Link clock, runs only in frames
  output logic serial_data_in, // Serial bit to driver
  output logic command_strobe, // Strobe, idles low
  output logic output_gate_low, // Gate, idles high
  input wire logic serial_chain_out // Bit from driver
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] chain_word;
  initial begin
    shift_clock = 1'b0;
    serial_data_in = 1'b0;
    command_strobe = 1'b0;
    output_gate_low = 1'b1;
    chain_word = 16'h0000;
  end
  // One 64 ns link cycle; takes the chain bit just before the rise, as a next driver would
  task automatic edge_out(input logic d, input int idx);
    serial_data_in = d;
    #16;
    if (idx >= 0) chain_word[idx] = serial_chain_out;
    shift_clock = 1'b1;
    #32 shift_clock = 1'b0;
    #16;
  endtask
  task automatic send_word(input logic [15:0] w);
    #7;
    for (int i = 15; i >= 0; i--) edge_out(w[i], i);
    serial_data_in = ~w[0];
  endtask
  task automatic strobe(input int n, input logic d);
    #8;
    serial_data_in = d;
    command_strobe = 1'b1;
    #80;
    repeat (n) edge_out(d, -1);
    #80 command_strobe = 1'b0;
    serial_data_in = ~d;
    #400;
  endtask
  task automatic gate(input logic v);
    output_gate_low = v;
  endtask
endmodule // led_ctl_model
`default_nettype wire

// ---- bench/tb_led_sink_serial_latch_ctrl.sv ----
`default_nettype none
`include "led_sink_defines.svh"
module tb_led_sink_serial_latch_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic nrst;
  wire logic shift_clock;
  wire logic serial_data_in;
  wire logic command_strobe;
  wire logic output_gate_low;
  wire logic serial_chain_out;
  wire logic precharge_active;
  wire logic ghost_reduction_on;
  wire logic latch_event;
  wire logic [`CHAIN_WIDTH-1:0] sink_channels;
  logic [`CHAIN_WIDTH-1:0] sreg;
  logic [`CHAIN_WIDTH-1:0] shown;
  wire logic [3:0] precharge_level;
  int errors = 0;
  int n_compared = 0;
  int n_latch = 0;
  led_sink_serial_latch_ctrl dut (.core_clk(core_clk), .nrst(nrst), .shift_clock(shift_clock),
    .serial_data_in(serial_data_in), .command_strobe(command_strobe), .output_gate_low(output_gate_low),
    .serial_chain_out(serial_chain_out), .sink_channels(sink_channels), .precharge_level(precharge_level),
    .precharge_active(precharge_active), .ghost_reduction_on(ghost_reduction_on), .latch_event(latch_event));
  led_ctl_model ctl (.shift_clock(shift_clock), .serial_data_in(serial_data_in),
    .command_strobe(command_strobe), .output_gate_low(output_gate_low), .serial_chain_out(serial_chain_out));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (latch_event === 1'b1) n_latch++;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Shift register after n more strobe edges with data d
  function automatic logic [15:0] shifted(input logic [15:0] w, input int n, input logic d);
    logic [31:0] t;
    t = {w, {16{d}}};
    return t[31-n -: 16];
  endfunction
  task automatic t_plain();
    int base;
    base = n_latch;
    ctl.send_word(16'hA5C3);
    check(ctl.chain_word, sreg);
    ctl.strobe(0, 1'b0);
    sreg = 16'hA5C3;
    @(negedge core_clk);
    check(16'(n_latch), 16'(base + 1));
    check(ghost_reduction_on, 1'b0);
    ctl.gate(1'b0);
    repeat (8) @(negedge core_clk);
    check(sink_channels, sreg);
    shown = sreg;
    ctl.gate(1'b1);
    repeat (8) @(negedge core_clk);
    check(sink_channels, 16'h0000);
    $display("test plain done");
  endtask
  task automatic t_ghost();
    for (int n = 1; n <= 3; n++) begin
      ctl.gate(1'b1);
      ctl.send_word(16'h1111 << n);
      check(ctl.chain_word, sreg);
      ctl.strobe(n, 1'b1);
      sreg = shifted(16'h1111 << n, n, 1'b1);
      @(negedge core_clk);
      check(ghost_reduction_on, 1'b1);
      check(precharge_active, 1'b1);
      check(sink_channels, 16'h0000);
      ctl.gate(1'b0);
      repeat (8) @(negedge core_clk);
      check(precharge_active, 1'b0);
      check(sink_channels, sreg);
      shown = sreg;
    end
    $display("test ghost done");
  endtask
  task automatic t_reserved();
    int base;
    for (int n = 4; n <= 12; n++) begin
      if (n == 11) continue;
      base = n_latch;
      ctl.send_word(16'hFFFF);
      check(sink_channels, shown);
      ctl.strobe(n, 1'b0);
      @(negedge core_clk);
      check(16'(n_latch), 16'(base));
      check(sink_channels, shown);
      check(precharge_level, 4'h0);
    end
    $display("test reserved done");
  endtask
  task automatic t_config();
    int base;
    logic [15:0] w [2];
    w = '{16'h0009, 16'h0016};
    for (int i = 0; i < 2; i++) begin
      base = n_latch;
      ctl.send_word(w[i]);
      ctl.strobe(11, 1'b0);
      sreg = shifted(w[i], 11, 1'b0);
      @(negedge core_clk);
      check(precharge_level, sreg[14:11]);
      check(sink_channels, shown);
      check(16'(n_latch), 16'(base));
    end
    $display("test config done");
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    complete_run();
  end
  initial begin
    sreg = 16'h0000;
    shown = 16'h0000;
    nrst = 1'b0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    check(sink_channels, 16'h0000);
    check(precharge_level, 4'h0);
    $display("test reset done");
    t_plain();
    t_ghost();
    t_reserved();
    t_config();
    complete_run();
  end
endmodule // tb_led_sink_serial_latch_ctrl
`default_nettype wire
